// ---- logic/spdtx_pkg.sv ----
// Package for the S/PDIF transmitter status bit generator.
// Assumes a single 10 MHz frame clock domain with a synchronous reset.
package spdtx_pkg;

  // ---------------------------------------------------------------------
  // Register offsets on the serial control port.
  // ---------------------------------------------------------------------
  localparam logic [6:0] SPDTX_OFS_CTRL     = 7'h1E; // Source and validity.
  localparam logic [6:0] SPDTX_OFS_FLAGS    = 7'h1F; // Status byte 1.
  localparam logic [6:0] SPDTX_OFS_CATEGORY = 7'h20; // Status byte 2.
  localparam logic [6:0] SPDTX_OFS_SRC_CHAN = 7'h21; // Status byte 3.
  localparam logic [6:0] SPDTX_OFS_RATE_ACC = 7'h22; // Status byte 4.
  localparam logic [6:0] SPDTX_OFS_WORD_LEN = 7'h23; // Status byte 5.

  // ---------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------
  localparam logic [7:0] SPDTX_RST_CTRL     = 8'h00; // Receiver source.
  localparam logic [7:0] SPDTX_RST_FLAGS    = 8'h00; // Consumer, PCM.
  localparam logic [7:0] SPDTX_RST_CATEGORY = 8'h00; // General category.
  localparam logic [7:0] SPDTX_RST_SRC_CHAN = 8'h00; // No channel number.
  localparam logic [7:0] SPDTX_RST_RATE_ACC = 8'h31; // Rate 0001, acc 11.
  localparam logic [7:0] SPDTX_RST_WORD_LEN = 8'h0B; // 24-bit, code 101.

  // ---------------------------------------------------------------------
  // Control register field positions.
  // ---------------------------------------------------------------------
  localparam int SPDTX_CTRL_SRC_LSB  = 0; // tx_source_select[1:0].
  localparam int SPDTX_CTRL_OVWCS    = 2; // override_received_status.
  localparam int SPDTX_CTRL_VAL_OVR  = 4; // validity_override_enable.
  localparam int SPDTX_CTRL_VAL_SF0  = 5; // validity_value_first_subframe.
  localparam int SPDTX_CTRL_VAL_SF1  = 6; // validity_value_second_subframe.

  // Source select codes.
  localparam logic [1:0] SPDTX_SRC_RECEIVER  = 2'h0;
  localparam logic [1:0] SPDTX_SRC_ADC       = 2'h1;
  localparam logic [1:0] SPDTX_SRC_SECONDARY = 2'h2;
  localparam logic [1:0] SPDTX_SRC_PRIMARY   = 2'h3;

  // Channel status block geometry.
  localparam logic [7:0] SPDTX_BLOCK_LAST = 8'hBF; // Frame 191.
  localparam int         SPDTX_CS_USED    = 40;    // Consumer bits used.

  // Subframe entering the generator from the audio source.
  typedef struct packed {
    logic [23:0] audio;        // Sample, aux nibble included.
    logic        second;       // 1 for the second subframe of a frame.
    logic        block_start;  // First subframe of frame 0 of a block.
    logic        rx_validity;  // Validity recovered by the receiver.
    logic        rx_user;      // User bit recovered by the receiver.
    logic        rx_status;    // Status bit recovered by the receiver.
  } spdtx_in_t;

  // Subframe leaving the generator toward the biphase coder.
  typedef struct packed {
    logic [23:0] audio;        // Sample, aux nibble included.
    logic        second;       // Subframe position.
    logic        block_start;  // Block start marker for the preamble.
    logic        validity;     // Transmitted validity bit.
    logic        user;         // Transmitted user bit.
    logic        status;       // Transmitted channel status bit.
    logic        parity;       // Even parity over bits 4 to 31.
  } spdtx_out_t;

endpackage

// ---- logic/spdtx_status_gen.sv ----
// Status bit generator for the consumer S/PDIF transmitter.
// Assumes subframes arrive in order, first then second, from the selected
// audio source, and that a biphase coder downstream drains the output.
module spdtx_status_gen (
  input  wire logic                 clk,         // 10 MHz frame clock.
  input  wire logic                 sys_rst,     // Synchronous reset.
  input  wire logic                 reg_wr,      // Register write strobe.
  input  wire logic [6:0]           reg_addr,    // Register address.
  input  wire logic [7:0]           reg_wdata,   // Register write data.
  output logic      [7:0]           reg_rdata,   // Registered readback.
  input  wire logic                 in_valid,    // Input subframe valid.
  output logic                      in_ready,    // Buffer has room.
  input  wire spdtx_pkg::spdtx_in_t in_word,     // Input subframe.
  output logic                      out_valid,   // Output subframe valid.
  input  wire logic                 out_ready,   // Coder takes subframe.
  output spdtx_pkg::spdtx_out_t     out_word     // Output subframe.
);

  // ---------------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------------
  logic [7:0] ctrl;            // Source and validity control.
  logic [7:0] cs_byte [5];     // Five channel status bytes.
  logic [7:0] next_ctrl;       // Next control value.
  logic [7:0] next_cs  [5];    // Next status byte values.
  logic [7:0] next_rdata;      // Next readback value.

  // Maps an address to a status byte index, or 7 when it is none.
  function automatic logic [2:0] cs_index(input logic [6:0] a);
    logic [6:0] d;
    d = a - spdtx_pkg::SPDTX_OFS_FLAGS;
    if (a >= spdtx_pkg::SPDTX_OFS_FLAGS &&
        a <= spdtx_pkg::SPDTX_OFS_WORD_LEN) begin
      cs_index = d[2:0];
    end else begin
      cs_index = 3'h7;
    end
  endfunction

  // Writes land in the addressed byte; unmapped addresses are ignored and
  // read back as zero. Software keeps the consumer and mode fields at zero.
  always_comb begin
    next_ctrl  = ctrl;
    next_rdata = 8'h00;
    for (int i = 0; i < 5; i++) begin
      next_cs[i] = cs_byte[i];
    end
    if (reg_wr && reg_addr == spdtx_pkg::SPDTX_OFS_CTRL) begin
      next_ctrl = reg_wdata;
    end else if (reg_wr && cs_index(reg_addr) != 3'h7) begin
      next_cs[cs_index(reg_addr)] = reg_wdata;
    end
    if (reg_addr == spdtx_pkg::SPDTX_OFS_CTRL) begin
      next_rdata = ctrl;
    end else if (cs_index(reg_addr) != 3'h7) begin
      next_rdata = cs_byte[cs_index(reg_addr)];
    end
  end

  // Registers take their documented defaults at reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl       <= spdtx_pkg::SPDTX_RST_CTRL;
      cs_byte[0] <= spdtx_pkg::SPDTX_RST_FLAGS;
      cs_byte[1] <= spdtx_pkg::SPDTX_RST_CATEGORY;
      cs_byte[2] <= spdtx_pkg::SPDTX_RST_SRC_CHAN;
      cs_byte[3] <= spdtx_pkg::SPDTX_RST_RATE_ACC;
      cs_byte[4] <= spdtx_pkg::SPDTX_RST_WORD_LEN;
      reg_rdata  <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      cs_byte   <= next_cs;
      reg_rdata <= next_rdata;
    end
  end

  // Decoded control fields.
  logic [1:0] src_sel;         // Transmit source select.
  logic       ovr_status;      // Use registers in receiver mode.
  logic       val_ovr;         // Validity override enable.
  assign src_sel    = ctrl[spdtx_pkg::SPDTX_CTRL_SRC_LSB +: 2];
  assign ovr_status = ctrl[spdtx_pkg::SPDTX_CTRL_OVWCS];
  assign val_ovr    = ctrl[spdtx_pkg::SPDTX_CTRL_VAL_OVR];

  // ---------------------------------------------------------------------
  // Channel status assembly.
  // ---------------------------------------------------------------------
  // Builds the 40 configurable bits for one subframe position. Only the
  // channel number pair differs, so a receiver can tell left from right.
  function automatic logic [39:0] cs_vector(input logic [7:0] b0,
                                            input logic [7:0] b1,
                                            input logic [7:0] b2,
                                            input logic [7:0] b3,
                                            input logic [7:0] b4,
                                            input logic       second);
    logic [39:0] v;
    v          = 40'h00_0000_0000;
    v[7:0]     = b0;
    v[15:8]    = b1;
    v[19:16]   = b2[3:0];
    v[21:20]   = second ? 2'h0 : b2[5:4];
    v[23:22]   = second ? b2[7:6] : 2'h0;
    v[27:24]   = b3[3:0];
    v[29:28]   = b3[5:4];
    v[39:32]   = b4;
    cs_vector  = v;
  endfunction

  // ---------------------------------------------------------------------
  // Frame position within the 192-frame block.
  // ---------------------------------------------------------------------
  logic [7:0] frame_idx;       // Frame of the next subframe.
  logic [7:0] next_frame_idx;  // Next frame position.
  logic [7:0] cur_idx;         // Frame of the subframe being taken.
  logic       push;            // Input subframe accepted.
  assign push = in_valid && in_ready;

  // Both subframes of a frame share one index, so each position walks
  // its own block in step with the other.
  always_comb begin
    cur_idx        = in_word.block_start ? 8'h00 : frame_idx;
    next_frame_idx = frame_idx;
    if (push) begin
      if (!in_word.second) begin
        next_frame_idx = cur_idx;
      end else if (cur_idx == spdtx_pkg::SPDTX_BLOCK_LAST) begin
        next_frame_idx = 8'h00;
      end else begin
        next_frame_idx = cur_idx + 8'h01;
      end
    end
  end

  // The index only moves on accepted subframes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_idx <= 8'h00;
    end else begin
      frame_idx <= next_frame_idx;
    end
  end

  // ---------------------------------------------------------------------
  // Status bit selection for the incoming subframe.
  // ---------------------------------------------------------------------
  spdtx_pkg::spdtx_out_t new_word;  // Subframe with its status bits.
  logic [39:0]           cs_reg;    // Register block for this position.
  logic                  from_rx;   // Receiver source selected.

  always_comb begin
    from_rx  = (src_sel == spdtx_pkg::SPDTX_SRC_RECEIVER);
    cs_reg   = cs_vector(cs_byte[0], cs_byte[1], cs_byte[2], cs_byte[3],
                         cs_byte[4], in_word.second);
    new_word = '0;
    new_word.audio       = in_word.audio;
    new_word.second      = in_word.second;
    new_word.block_start = in_word.block_start;
    // The override wins over both the default and the recovered bit.
    if (val_ovr) begin
      new_word.validity = in_word.second ?
                          ctrl[spdtx_pkg::SPDTX_CTRL_VAL_SF1] :
                          ctrl[spdtx_pkg::SPDTX_CTRL_VAL_SF0];
    end else if (from_rx) begin
      new_word.validity = in_word.rx_validity;
    end else begin
      new_word.validity = 1'b0;
    end
    // User data cannot be configured, so only the receiver supplies it.
    new_word.user = from_rx ? in_word.rx_user : 1'b0;
    if (from_rx && !ovr_status) begin
      new_word.status = in_word.rx_status;
    end else if (cur_idx < 8'(spdtx_pkg::SPDTX_CS_USED)) begin
      new_word.status = cs_reg[cur_idx[5:0]];
    end else begin
      new_word.status = 1'b0;
    end
    // Preamble is not part of the word, so the parity covers the rest.
    new_word.parity = ^{in_word.audio, new_word.validity, new_word.user,
                        new_word.status};
  end

  // ---------------------------------------------------------------------
  // Two-entry output buffer.
  // ---------------------------------------------------------------------
  // Two slots let the coder stall for a cycle without the source losing
  // its word; the head slot drives the outputs straight from flops.
  spdtx_pkg::spdtx_out_t slot1;       // Second slot.
  logic                  slot1_vld;   // Second slot occupied.
  spdtx_pkg::spdtx_out_t next_head;   // Next head slot.
  spdtx_pkg::spdtx_out_t next_slot1;  // Next second slot.
  logic                  next_hvld;   // Next head occupancy.
  logic                  next_s1vld;  // Next second occupancy.
  logic                  next_in_ready; // Next ready to the source.
  logic                  pop;         // Head taken by the coder.
  assign pop = out_valid && out_ready;

  always_comb begin
    next_head  = out_word;
    next_slot1 = slot1;
    next_hvld  = out_valid;
    next_s1vld = slot1_vld;
    if (pop) begin
      next_head  = slot1;
      next_hvld  = slot1_vld;
      next_s1vld = 1'b0;
    end
    if (push) begin
      if (!next_hvld) begin
        next_head = new_word;
        next_hvld = 1'b1;
      end else begin
        next_slot1 = new_word;
        next_s1vld = 1'b1;
      end
    end
    // Room for one more word exists only while the second slot is free.
    next_in_ready = !next_s1vld;
  end

  // Ready only reflects a free second slot, which keeps it a flop output.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_word  <= '0;
      slot1     <= '0;
      out_valid <= 1'b0;
      slot1_vld <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      out_word  <= next_head;
      slot1     <= next_slot1;
      out_valid <= next_hvld;
      slot1_vld <= next_s1vld;
      in_ready  <= next_in_ready;
    end
  end

  // ---------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_stalled;
    out_valid && !out_ready;
  endsequence

  sequence s_held;
    out_valid && $stable(out_word);
  endsequence

  a_parity_even: assert property (
    out_valid |-> (^out_word) == (^{out_word.second,
                                     out_word.block_start}))
    else $error("Output subframe parity is odd.");

  a_validity_default: assert property (
    push && !val_ovr && src_sel != spdtx_pkg::SPDTX_SRC_RECEIVER
    |-> !new_word.validity)
    else $error("Validity not zero for a non-receiver source.");

  a_validity_recv: assert property (
    push && !val_ovr && src_sel == spdtx_pkg::SPDTX_SRC_RECEIVER
    |-> new_word.validity == in_word.rx_validity)
    else $error("Recovered validity not forwarded.");

  a_validity_ovr: assert property (
    push && val_ovr |-> new_word.validity ==
      (in_word.second ? ctrl[spdtx_pkg::SPDTX_CTRL_VAL_SF1]
                      : ctrl[spdtx_pkg::SPDTX_CTRL_VAL_SF0]))
    else $error("Override validity does not follow its setting.");

  a_user_bits: assert property (
    push |-> new_word.user ==
      (src_sel == spdtx_pkg::SPDTX_SRC_RECEIVER && in_word.rx_user))
    else $error("User bit source is wrong.");

  a_status_recv: assert property (
    push && src_sel == spdtx_pkg::SPDTX_SRC_RECEIVER && !ovr_status
    |-> new_word.status == in_word.rx_status)
    else $error("Recovered status not resent.");

  a_status_unused: assert property (
    push && (src_sel != spdtx_pkg::SPDTX_SRC_RECEIVER || ovr_status) &&
    cur_idx >= 8'(spdtx_pkg::SPDTX_CS_USED) |-> !new_word.status)
    else $error("Unused status bit not zero.");

  a_block_wrap: assert property (
    push && in_word.second && cur_idx == spdtx_pkg::SPDTX_BLOCK_LAST
    |=> frame_idx == 8'h00)
    else $error("Block index did not wrap after frame 191.");

  a_stall_hold: assert property (
    s_stalled |=> s_held)
    else $error("Output changed while the coder stalled.");

  // Register blocks of both positions, spelled out for the check below;
  // only the channel number nibble may tell them apart.
  logic [39:0] cs_first;   // Block sent in first subframes.
  logic [39:0] cs_second;  // Block sent in second subframes.
  assign cs_first  = cs_vector(cs_byte[0], cs_byte[1], cs_byte[2],
                               cs_byte[3], cs_byte[4], 1'b0);
  assign cs_second = cs_vector(cs_byte[0], cs_byte[1], cs_byte[2],
                               cs_byte[3], cs_byte[4], 1'b1);

  a_chan_only_diff: assert property (
    ((cs_first ^ cs_second) & 40'hFF_FF0F_FFFF) == 40'h00_0000_0000)
    else $error("Status blocks differ outside the channel bits.");

  // When the registers supply the status, a block start must restart at the consumer flag whatever the count.
  a_frame0_flag: assert property (
    push && in_word.block_start &&
    (src_sel != spdtx_pkg::SPDTX_SRC_RECEIVER || ovr_status)
    |-> new_word.status == cs_byte[0][0])
    else $error("Frame zero does not carry the consumer flag.");

endmodule

// ---- testbench/spdtx_sink.sv ----
// Far-side model: the biphase coder that drains the status generator.
// Assumes one clock shared with the generator and a synchronous reset.
module spdtx_sink (
  input  wire logic       clk,     // Frame clock.
  input  wire logic       sys_rst, // Synchronous reset.
  input  wire logic [1:0] mode,    // 0 prompt, 1 slow, 2 hold.
  input  wire logic       valid,   // Generator offers a subframe.
  output logic            ready    // Coder takes the subframe.
);
  timeunit 1ns;
  timeprecision 1ns;

  // -------------------------------------------------------------------
  // Pacing
  // -------------------------------------------------------------------
  logic [1:0] pace; // Free count that spaces slow-mode takes.

  // Slow mode takes one word in four cycles, so the generator's buffer
  // really fills; hold mode stalls until the bench lets go.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pace  <= 2'h0;
      ready <= 1'b0;
    end else begin
      pace  <= pace + 2'h1;
      ready <= (mode == 2'h0) || (mode == 2'h1 && pace == 2'h3);
    end
  end
endmodule

// ---- testbench/spdtx_status_gen_bench.sv ----
// Self-checking bench for the transmitter status bit generator.
// Assumes the package types and the sink model compiled before it.
module spdtx_status_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic                  clk = 1'b0;       // 10 MHz clock.
  logic                  sys_rst = 1'b1;   // Reset, held at start.
  logic                  reg_wr = 1'b0;    // Register write strobe.
  logic [6:0]            reg_addr = 7'h00; // Register address.
  logic [7:0]            reg_wdata = 8'h00;// Write data.
  logic [7:0]            reg_rdata;        // Readback.
  logic                  in_valid = 1'b0;  // Source offers subframe.
  logic                  in_ready;         // Generator has room.
  spdtx_pkg::spdtx_in_t  in_word = '0;     // Source subframe.
  logic                  out_valid;        // Generator offers word.
  logic                  out_ready;        // Sink takes word.
  spdtx_pkg::spdtx_out_t out_word;         // Generated subframe.
  logic [1:0]            mode = 2'h0;      // Sink pacing.
  logic [7:0]            rg [6];           // Expected register file.
  spdtx_pkg::spdtx_out_t rxq [$];          // Words taken by the sink.
  int                    num_errors = 0;   // Mismatches.
  int                    samples_checked = 0; // Comparisons.

  initial forever #50 clk = ~clk;

  spdtx_status_gen dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
  spdtx_sink u_sink (.clk(clk), .sys_rst(sys_rst), .mode(mode),
    .valid(out_valid), .ready(out_ready));

  // Record every handshake; values are the ones before the edge lands.
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) rxq.push_back(out_word);
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    num_errors++;
    $display("[FAIL] wait expected done seen timeout");
    end_sim();
  endtask

  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a >= 7'h1E && a <= 7'h23) rg[int'(a) - 30] = d;
  endtask

  // Readback is registered, so the value lands one edge after the address.
  task automatic rd_chk(logic [6:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 check("reg_rdata", 32'(e), 32'(reg_rdata));
  endtask

  // Subframe k of a run; the block starts at k = 0.
  function automatic spdtx_pkg::spdtx_in_t mk(int k);
    spdtx_pkg::spdtx_in_t w;
    w.audio = 24'(k * 24'h0131);
    w.second = k[0];
    w.block_start = (k == 0);
    w.rx_validity = k[1];
    w.rx_user = k[2];
    w.rx_status = k[0] ^ k[3];
    return w;
  endfunction

  function automatic spdtx_pkg::spdtx_out_t exp_word(int k);
    spdtx_pkg::spdtx_in_t  w;
    spdtx_pkg::spdtx_out_t e;
    logic [39:0]           v;
    int                    idx;
    logic                  rcv;
    w = mk(k);
    idx = (k / 2) % 192;
    rcv = (rg[0][1:0] == 2'h0);
    v = {rg[5], 2'h0, rg[4][5:0],
         w.second ? {rg[3][7:6], 2'h0} : {2'h0, rg[3][5:4]},
         rg[3][3:0], rg[2], rg[1]};
    e.audio = w.audio;
    e.second = w.second;
    e.block_start = w.block_start;
    e.validity = rg[0][4] ? (w.second ? rg[0][6] : rg[0][5])
                          : (rcv ? w.rx_validity : 1'b0);
    e.user = rcv ? w.rx_user : 1'b0;
    e.status = (rcv && !rg[0][2]) ? w.rx_status
                                  : (idx < 40 ? v[idx] : 1'b0);
    e.parity = ^{e.audio, e.validity, e.user, e.status};
    return e;
  endfunction

  // Holds the offer until taken or until the bound runs out.
  task automatic push(spdtx_pkg::spdtx_in_t w, int lim, output bit ok);
    logic r;
    in_valid <= 1'b1;
    in_word <= w;
    ok = 0;
    for (int t = 0; t < lim && !ok; t++) begin
      @(negedge clk);
      r = in_ready;
      @(posedge clk);
      ok = (r === 1'b1);
    end
  endtask

  task automatic get_chk(int k);
    for (int t = 0; t < 400 && rxq.size() == 0; t++) @(negedge clk);
    if (rxq.size() == 0) hang();
    check("out_word", 32'(exp_word(k)), 32'(rxq.pop_front()));
  endtask

  task automatic run_frames(int n);
    bit ok;
    fork
      begin
        @(posedge clk);
        for (int i = 0; i < 2 * n; i++) begin
          push(mk(i), 200, ok);
          if (!ok) hang();
        end
        in_valid <= 1'b0;
      end
      for (int k = 0; k < 2 * n; k++) get_chk(k);
    join
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic s_reset;
    for (int a = 30; a <= 36; a++) rd_chk(7'(a), a == 36 ? 8'h00 : rg[a - 30]);
  endtask

  // Flags keep bit 0 and the mode at 0 and the emphasis code at 011.
  task automatic s_regs;
    wr(7'h1F, 8'h1E);
    wr(7'h20, 8'hA5);
    wr(7'h21, 8'h9C);
    wr(7'h22, 8'h2D);
    wr(7'h23, 8'hC7);
    wr(7'h1E, 8'h01);
    wr(7'h24, 8'hFF);
    for (int a = 30; a <= 36; a++) rd_chk(7'(a), a == 36 ? 8'h00 : rg[a - 30]);
  endtask

  // Slow sink; 194 frames so the frame index wraps past 191.
  task automatic s_block;
    @(posedge clk);
    mode <= 2'h1;
    run_frames(194);
  endtask

  // Every source code, the status override and both validity overrides.
  task automatic s_modes;
    logic [7:0] tbl [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h30, 8'h52};
    @(posedge clk);
    mode <= 2'h0;
    foreach (tbl[j]) begin
      wr(7'h1E, tbl[j]);
      run_frames(41);
    end
  endtask

  // Sink holds until the buffer refuses, then drains in order.
  task automatic s_fill;
    bit ok;
    int n;
    @(posedge clk);
    mode <= 2'h2;
    ok = 1;
    for (n = 0; n < 8 && ok; n++) push(mk(n), 6, ok);
    n--;
    check("refused", 32'h1, 32'(!ok));
    mode <= 2'h0;
    push(mk(n), 200, ok);
    if (!ok) hang();
    in_valid <= 1'b0;
    for (int k = 0; k <= n; k++) get_chk(k);
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    rg = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0B};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    s_reset();
    s_regs();
    s_block();
    s_modes();
    s_fill();
    end_sim();
  end
endmodule
